/* File: besl_pkg.sv */
package besl_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Bus geometry
    localparam int          DATA_W        = 32;
    localparam int          ADDR_W        = 4;
    localparam int          BE_W          = DATA_W / 8;

    // Register byte offsets
    localparam logic [3:0]  OFF_DIAG      = 4'h0;
    localparam logic [3:0]  OFF_SYS_ADDR  = 4'h4;
    localparam logic [3:0]  OFF_PCI_ADDR  = 4'h8;
    localparam logic [3:0]  OFF_IRQ_MASK  = 4'hC;

    ////////////////////////////////////////////////////////////////////////
    // Diagnostic control and status field positions
    localparam int          FLAG_W        = 16;
    localparam int          BIT_MEM       = 15;
    localparam int          BIT_MAP       = 14;
    localparam int          BIT_UNCORR    = 13;
    localparam int          BIT_CORR      = 12;
    localparam int          BIT_NODEV     = 11;
    localparam int          BIT_TARGET_ABORT_FLAG      = 10;
    localparam int          BIT_IO_PARITY_ERROR_FLAG      = 9;
    localparam int          BIT_DPE       = 8;
    localparam int          BIT_LOST      = 6;
    localparam int          BIT_RETRY     = 5;
    localparam int          BIT_DISABLE_CORRECTABLE_ERROR_INTERRUPT      = 3;

    // Write-to-clear bits, and the flags that log into each address register
    localparam logic [15:0] FLAG_RWC_MASK = 16'hFF60;
    localparam logic [15:0] SYS_GROUP     = 16'hB000;
    localparam logic [15:0] PCI_GROUP     = 16'h4F20;
    localparam logic [15:0] CTRL_RW_MASK  = 16'h0008;
    localparam logic [15:0] DIAG_RESET    = 16'h0000;
    localparam logic [15:0] MASK_RESET    = 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // Address capture layout
    localparam int          SYS_ADR_W     = 34;
    localparam int          SYS_ADR_LSB   = 6;
    localparam int          SYS_FIELD_LSB = 4;
    localparam int          SYS_FIELD_W   = 28;
    localparam int          PCI_FIELD_W   = 32;
    localparam int          ACK_W         = 2;

    ////////////////////////////////////////////////////////////////////////
    // Bus slave states
    typedef enum logic [1:0]
    {
        BESL_ST_IDLE   = 2'h1,
        BESL_ST_ANSWER = 2'h2
    } besl_slave_st_t;

endpackage : besl_pkg

/* File: besl_addr_log.sv */
`timescale 1ns/100ps
module besl_addr_log
#(
    parameter int W = 32
)
(
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         capture,
    input  wire logic [W-1:0] addrIn,
    input  wire logic         unlock,
    output      logic         locked,
    output      logic [W-1:0] addr
);
    import besl_pkg::*;

    logic         lock_ff;
    logic         nxt_lock;
    logic [W-1:0] addr_ff;
    logic [W-1:0] nxt_addr;

    initial
    begin
        if (W < 1)
            $error("besl_addr_log: W must be at least 1");
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        nxt_lock = lock_ff;
        nxt_addr = addr_ff;
        if (capture && !lock_ff)
        begin
            nxt_lock = 1'b1;
            nxt_addr = addrIn;
        end
        else if (unlock)
        begin
            nxt_lock = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            lock_ff <= 1'b0;
            addr_ff <= '0;
        end
        else
        begin
            lock_ff <= nxt_lock;
            addr_ff <= nxt_addr;
        end
    end

    assign locked = lock_ff;
    assign addr   = addr_ff;

endmodule : besl_addr_log

/* File: besl_bus_slave.sv */
`timescale 1ns/100ps
module besl_bus_slave
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic read,
    input  wire logic write,
    output      logic waitrequest,
    output      logic rdLoad,
    output      logic wrAccept
);
    import besl_pkg::*;

    besl_slave_st_t state_ff;
    besl_slave_st_t nxt_state;
    logic           waitReq_ff;
    logic           nxt_waitReq;

    ////////////////////////////////////////////////////////////////////////
    // One wait state, then the answer cycle
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            BESL_ST_IDLE:
            begin
                if (read || write)
                    nxt_state = BESL_ST_ANSWER;
            end
            BESL_ST_ANSWER:
            begin
                nxt_state = BESL_ST_IDLE;
            end
            default:
            begin
                nxt_state = BESL_ST_IDLE;
            end
        endcase
        nxt_waitReq = (nxt_state != BESL_ST_ANSWER);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_ff   <= BESL_ST_IDLE;
            waitReq_ff <= 1'b1;
        end
        else
        begin
            state_ff   <= nxt_state;
            waitReq_ff <= nxt_waitReq;
        end
    end

    assign waitrequest = waitReq_ff;
    assign rdLoad      = read && (state_ff == BESL_ST_IDLE);
    assign wrAccept    = write && (state_ff == BESL_ST_ANSWER);

endmodule : besl_bus_slave

/* File: besl_error_log.sv */
`timescale 1ns/100ps
module besl_error_log
    import besl_pkg::*;
#(
    parameter logic [1:0] ACK_ERROR_CODE = 2'h3
)
(
    input  wire logic                          clk,
    input  wire logic                          rst,
    // Avalon-MM slave
    input  wire logic [besl_pkg::ADDR_W-1:0]   address,
    input  wire logic                          read,
    input  wire logic                          write,
    input  wire logic [besl_pkg::BE_W-1:0]     byteenable,
    input  wire logic [besl_pkg::DATA_W-1:0]   writedata,
    output      logic [besl_pkg::DATA_W-1:0]   readdata,
    output      logic                          waitrequest,
    output      logic                          irq,
    // Memory controller answers
    input  wire logic                          memAckValid,
    input  wire logic [besl_pkg::ACK_W-1:0]    controllerAcknowledgeCode,
    input  wire logic [besl_pkg::SYS_ADR_W-1:0] systemBusAddress,
    input  wire logic                          uncorrReadErr,
    input  wire logic                          corrReadErr,
    // PCI side events
    input  wire logic [besl_pkg::PCI_FIELD_W-1:0] pciAddrData,
    input  wire logic                          mapLookupInvalid,
    input  wire logic                          noDeviceErr,
    input  wire logic                          targetAbortErr,
    input  wire logic                          ioParityErr,
    input  wire logic                          dmaParityErr,
    input  wire logic                          retryTimeoutErr
);
    import besl_pkg::*;

    logic [FLAG_W-1:0]      diag_ff;
    logic [FLAG_W-1:0]      nxt_diag;
    logic [FLAG_W-1:0]      mask_ff;
    logic [FLAG_W-1:0]      nxt_mask;
    logic [DATA_W-1:0]      readdata_ff;
    logic [DATA_W-1:0]      nxt_readdata;
    logic                   irq_ff;
    logic                   nxt_irq;

    logic                   rdLoad;
    logic                   wrAccept;
    logic [DATA_W-1:0]      beMask;
    logic [FLAG_W-1:0]      wrBits;
    logic [FLAG_W-1:0]      events;
    logic                   memErrEvt;
    logic                   corrEvt;
    logic                   sysEvt;
    logic                   pciEvt;
    logic                   sysLocked;
    logic                   pciLocked;
    logic                   sysUnlock;
    logic                   pciUnlock;
    logic [SYS_FIELD_W-1:0] sysAddr;
    logic [PCI_FIELD_W-1:0] pciAddr;
    logic [DATA_W-1:0]      sysWord;
    logic [SYS_FIELD_W-1:0] sysCapt;
    logic [FLAG_W-1:0]      wrLanes;
    logic                   wrDiag;
    logic                   wrMask;
    logic                   lostSys;
    logic                   lostPci;
    logic [DATA_W-1:0]      diagWord;
    logic [DATA_W-1:0]      maskWord;

    initial
    begin
        if (DATA_W != 32 || FLAG_W > DATA_W)
            $error("besl_error_log: register width unsupported");
        if (ADDR_W < 4)
            $error("besl_error_log: address too narrow for the map");
        if (SYS_FIELD_LSB + SYS_FIELD_W != DATA_W)
            $error("besl_error_log: system field must fill a word");
        if (SYS_ADR_LSB + SYS_FIELD_W != SYS_ADR_W)
            $error("besl_error_log: system address slice out of range");
        if (PCI_FIELD_W != DATA_W)
            $error("besl_error_log: PCI field must fill a word");
        if ($bits(ACK_ERROR_CODE) != ACK_W)
            $error("besl_error_log: acknowledge code width mismatch");
        if ((SYS_GROUP & PCI_GROUP) != '0)
            $error("besl_error_log: address lock groups overlap");
        if (((SYS_GROUP | PCI_GROUP) & ~FLAG_RWC_MASK) != '0)
            $error("besl_error_log: lock group holds a plain bit");
        if ((FLAG_RWC_MASK & CTRL_RW_MASK) != '0)
            $error("besl_error_log: control bit also write-to-clear");
        if (!CTRL_RW_MASK[BIT_DISABLE_CORRECTABLE_ERROR_INTERRUPT])
            $error("besl_error_log: disable bit not writable");
    end

    ////////////////////////////////////////////////////////////////////////
    // Register select, used by both read and write paths
    function automatic logic regHit
    (
        input logic [ADDR_W-1:0] a,
        input logic [ADDR_W-1:0] off
    );
        regHit = (a == off);
    endfunction : regHit

    // True when no flag of a lock group is left set
    function automatic logic groupClear
    (
        input logic [FLAG_W-1:0] flags,
        input logic [FLAG_W-1:0] group
    );
        groupClear = ((flags & group) == '0);
    endfunction : groupClear

    ////////////////////////////////////////////////////////////////////////
    // Bus handshake
    besl_bus_slave u_slave
    (
        .clk         (clk),
        .rst         (rst),
        .read        (read),
        .write       (write),
        .waitrequest (waitrequest),
        .rdLoad      (rdLoad),
        .wrAccept    (wrAccept)
    );

    ////////////////////////////////////////////////////////////////////////
    // Byte lanes of a write
    genvar gi;
    generate
        for (gi = 0; gi < BE_W; gi++)
        begin : g_be
            assign beMask[gi*8 +: 8] = {8{byteenable[gi]}};
        end
    endgenerate

    assign wrBits  = writedata[FLAG_W-1:0] & beMask[FLAG_W-1:0];
    assign wrLanes = beMask[FLAG_W-1:0];
    assign wrDiag  = wrAccept && regHit(address, OFF_DIAG);
    assign wrMask  = wrAccept && regHit(address, OFF_IRQ_MASK);

    ////////////////////////////////////////////////////////////////////////
    // Event qualification
    always_comb
    begin
        memErrEvt = memAckValid
                 && (controllerAcknowledgeCode == ACK_ERROR_CODE);
        corrEvt   = corrReadErr && !diag_ff[BIT_DISABLE_CORRECTABLE_ERROR_INTERRUPT];
        sysEvt    = memErrEvt || uncorrReadErr || corrEvt;
        pciEvt    = mapLookupInvalid || noDeviceErr || targetAbortErr
                 || ioParityErr || dmaParityErr || retryTimeoutErr;

        events             = '0;
        events[BIT_MEM]    = memErrEvt && !sysLocked;
        events[BIT_MAP]    = mapLookupInvalid;
        events[BIT_UNCORR] = uncorrReadErr;
        events[BIT_CORR]   = corrEvt;
        events[BIT_NODEV]  = noDeviceErr;
        events[BIT_TARGET_ABORT_FLAG]   = targetAbortErr;
        events[BIT_IO_PARITY_ERROR_FLAG]   = ioParityErr;
        events[BIT_DPE]    = dmaParityErr;
        events[BIT_RETRY]  = retryTimeoutErr;
        lostSys            = sysEvt && sysLocked;
        lostPci            = pciEvt && pciLocked;
        events[BIT_LOST]   = lostSys || lostPci;
    end

    ////////////////////////////////////////////////////////////////////////
    // Diagnostic control and status, interrupt mask
    always_comb
    begin
        nxt_diag = diag_ff;
        nxt_mask = mask_ff;
        if (wrDiag)
        begin
            nxt_diag = (diag_ff & ~(wrBits & FLAG_RWC_MASK));
            nxt_diag = (nxt_diag & ~(wrLanes & CTRL_RW_MASK))
                     | (wrBits & CTRL_RW_MASK);
        end
        else if (wrMask)
        begin
            nxt_mask = (mask_ff & ~(wrLanes & FLAG_RWC_MASK))
                     | (wrBits & FLAG_RWC_MASK);
        end
        // Set wins over a clear in the same cycle
        nxt_diag = nxt_diag | events;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            diag_ff <= DIAG_RESET;
            mask_ff <= MASK_RESET;
        end
        else
        begin
            diag_ff <= nxt_diag;
            mask_ff <= nxt_mask;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Level interrupt, one cycle behind the flags
    always_comb
    begin
        nxt_irq = |(diag_ff & mask_ff);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            irq_ff <= 1'b0;
        else
            irq_ff <= nxt_irq;
    end

    ////////////////////////////////////////////////////////////////////////
    // Error address registers
    // A lock drops once its whole flag group is clear
    assign sysUnlock = groupClear(nxt_diag, SYS_GROUP);
    assign pciUnlock = groupClear(nxt_diag, PCI_GROUP);
    assign sysCapt   = systemBusAddress[SYS_ADR_LSB +: SYS_FIELD_W];

    // System address bits 33:6 into field 31:4; first capture held
    besl_addr_log #(.W(SYS_FIELD_W)) u_sys_log
    (
        .clk    (clk),
        .rst    (rst),
        .capture(sysEvt),
        .addrIn (sysCapt),
        .unlock (sysUnlock),
        .locked (sysLocked),
        .addr   (sysAddr)
    );

    // AD 31:0 captured on any PCI error; first capture held
    besl_addr_log #(.W(PCI_FIELD_W)) u_pci_log
    (
        .clk    (clk),
        .rst    (rst),
        .capture(pciEvt),
        .addrIn (pciAddrData),
        .unlock (pciUnlock),
        .locked (pciLocked),
        .addr   (pciAddr)
    );

    assign sysWord  = {sysAddr, {SYS_FIELD_LSB{1'b0}}};
    assign diagWord = {{(DATA_W-FLAG_W){1'b0}},
                       diag_ff & (FLAG_RWC_MASK | CTRL_RW_MASK)};
    assign maskWord = {{(DATA_W-FLAG_W){1'b0}}, mask_ff};

    ////////////////////////////////////////////////////////////////////////
    // Read data, latched in the wait cycle
    always_comb
    begin
        nxt_readdata = readdata_ff;
        if (rdLoad)
        begin
            if (regHit(address, OFF_DIAG))
                nxt_readdata = diagWord;
            else if (regHit(address, OFF_SYS_ADDR))
                nxt_readdata = sysWord;
            else if (regHit(address, OFF_PCI_ADDR))
                nxt_readdata = pciAddr;
            else if (regHit(address, OFF_IRQ_MASK))
                nxt_readdata = maskWord;
            // Unmapped offsets read as zero
            else
                nxt_readdata = '0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            readdata_ff <= '0;
        else
            readdata_ff <= nxt_readdata;
    end

    assign readdata = readdata_ff;
    assign irq      = irq_ff;

endmodule : besl_error_log

/* File: besl_error_log_props.sv */
`timescale 1ns/100ps
module besl_error_log_props
    import besl_pkg::*;
(
    input wire logic                        clk,
    input wire logic                        rst,
    input wire logic [besl_pkg::ADDR_W-1:0] address,
    input wire logic                        read,
    input wire logic                        write,
    input wire logic [besl_pkg::DATA_W-1:0] readdata,
    input wire logic                        waitrequest,
    input wire logic                        irq
);
    import besl_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    logic rdAns;
    assign rdAns = read && !waitrequest;
    ////////////////////////////////////////////////////////////////////
    chk_wait_answer: assert property (
        (read || write) && waitrequest |=> !waitrequest)
        else $error("no answer one cycle after request");
    chk_wait_idle: assert property (
        !read && !write |=> waitrequest)
        else $error("answer without request");
    chk_wait_single: assert property (!waitrequest |=> waitrequest)
        else $error("answer held too long");
    chk_diag_layout: assert property (
        rdAns && address == OFF_DIAG |-> (readdata & 32'hFFFF0097) == 32'h0)
        else $error("diag reserved bits not zero");
    chk_mask_layout: assert property (
        rdAns && address == OFF_IRQ_MASK |->
        (readdata & 32'hFFFF009F) == 32'h0)
        else $error("mask reserved bits not zero");
    chk_sys_low: assert property (
        rdAns && address == OFF_SYS_ADDR |-> readdata[3:0] == 4'h0)
        else $error("system address low bits not zero");
    chk_unmapped_zero: assert property (
        rdAns && address[1:0] != 2'h0 |-> readdata == 32'h0)
        else $error("unmapped read not zero");
    chk_irq_hold: assert property (irq && !$past(write) |=> irq)
        else $error("interrupt dropped without a write");
    chk_irq_fall: assert property (
        $fell(irq) && !$past(rst) |-> $past(write, 2))
        else $error("interrupt fell without a clearing write");
    cov_read_mem: cover property (rdAns && address == OFF_DIAG && readdata[15]);
    cov_irq_rise: cover property ($rose(irq));
    cov_mask_wr: cover property (write && !waitrequest && address == OFF_IRQ_MASK);
endmodule : besl_error_log_props

/* File: besl_far_side.sv */
`timescale 1ns/100ps
module besl_far_side
    import besl_pkg::*;
#(
    parameter logic [1:0] ACK_ERR = 2'h3
)
(
    input  wire logic                             clk,
    input  wire logic                             go,
    input  wire logic                             slow,
    input  wire logic [3:0]                       kind,
    input  wire logic [besl_pkg::SYS_ADR_W-1:0]   sa,
    input  wire logic [besl_pkg::PCI_FIELD_W-1:0] ad,
    output      logic                             memAckValid,
    output      logic [besl_pkg::ACK_W-1:0]       controllerAcknowledgeCode,
    output      logic [besl_pkg::SYS_ADR_W-1:0]   systemBusAddress,
    output      logic [besl_pkg::PCI_FIELD_W-1:0] pciAddrData,
    output      logic                             uncorrReadErr,
    output      logic                             corrReadErr,
    output      logic                             mapLookupInvalid,
    output      logic                             noDeviceErr,
    output      logic                             targetAbortErr,
    output      logic                             ioParityErr,
    output      logic                             dmaParityErr,
    output      logic                             retryTimeoutErr
);
    import besl_pkg::*;
    logic [9:0]             hit;
    logic [3:0]             kindQ;
    logic                   pend;
    logic                   lag;
    logic [SYS_ADR_W-1:0]   saQ;
    logic [PCI_FIELD_W-1:0] adQ;
    ////////////////////////////////////////////////////////////////////
    initial
    begin
        hit = '0;
        pend = 1'b0;
        lag = 1'b0;
        saQ = '0;
        adQ = '0;
    end
    // Slow answers wait one extra cycle
    always @(posedge clk)
    begin
        hit <= (!go && pend && !lag) ? (10'h001 << kindQ) : '0;
        if (go)
        begin
            pend <= 1'b1;
            lag <= slow;
            kindQ <= kind;
            saQ <= sa;
            adQ <= ad;
        end
        else if (pend && lag)
            lag <= 1'b0;
        else if (pend)
            pend <= 1'b0;
    end
    assign memAckValid = hit[0] | hit[1];
    assign controllerAcknowledgeCode = hit[0] ? ACK_ERR : 2'h0;
    // Idle lines show the inverse of the last value
    assign systemBusAddress = (hit != '0) ? saQ : ~saQ;
    assign pciAddrData = (hit != '0) ? adQ : ~adQ;
    assign uncorrReadErr = hit[2];
    assign corrReadErr = hit[3];
    assign mapLookupInvalid = hit[4];
    assign noDeviceErr = hit[5];
    assign targetAbortErr = hit[6];
    assign ioParityErr = hit[7];
    assign dmaParityErr = hit[8];
    assign retryTimeoutErr = hit[9];
endmodule : besl_far_side

/* File: bridge_error_status_logging_test.sv */
`timescale 1ns/100ps
`define CHK(a, b) \
    begin \
        tests_run++; \
        if ((a) !== (b)) \
        begin \
            error_cnt++; \
            $display("ERROR %0t got %h exp %h", $time, a, b); \
        end \
    end
`define RD(a, e) \
    begin \
        acc(1'b0, a, 32'h0, q); \
        `CHK(q, e) \
    end
module bridge_error_status_logging_test;
    import besl_pkg::*;
    typedef struct packed {logic [3:0] k; logic [15:0] f; logic [3:0] o;}
        besl_row_t;
    localparam logic [1:0] ACK_ERR = 2'h3;
    logic        clk, rst, read, write, go, slow, waitrequest, irq;
    logic        memAckValid, uncorrReadErr, corrReadErr, noDeviceErr;
    logic        mapLookupInvalid, targetAbortErr, ioParityErr;
    logic        dmaParityErr, retryTimeoutErr;
    logic [1:0]  controllerAcknowledgeCode;
    logic [3:0]  address, kind, byteenable;
    logic [31:0] writedata, readdata, pciAddrData, ad, q, e;
    logic [33:0] systemBusAddress, sa, sv, sv2;
    int          error_cnt, tests_run;
    besl_row_t   rows [10] = '{
        '{4'h0, 16'h8000, OFF_SYS_ADDR},
        '{4'h1, 16'h0000, OFF_DIAG},
        '{4'h2, 16'h2000, OFF_SYS_ADDR},
        '{4'h3, 16'h1000, OFF_SYS_ADDR},
        '{4'h4, 16'h4000, OFF_PCI_ADDR},
        '{4'h5, 16'h0800, OFF_PCI_ADDR},
        '{4'h6, 16'h0400, OFF_PCI_ADDR},
        '{4'h7, 16'h0200, OFF_PCI_ADDR},
        '{4'h8, 16'h0100, OFF_PCI_ADDR},
        '{4'h9, 16'h0020, OFF_PCI_ADDR}
    };
    besl_error_log #(.ACK_ERROR_CODE(ACK_ERR)) i_dut
    (
        .clk, .rst, .address, .read, .write, .byteenable, .writedata,
        .readdata, .waitrequest, .irq, .memAckValid,
        .controllerAcknowledgeCode, .systemBusAddress, .uncorrReadErr,
        .corrReadErr, .pciAddrData, .mapLookupInvalid, .noDeviceErr,
        .targetAbortErr, .ioParityErr, .dmaParityErr, .retryTimeoutErr
    );
    besl_far_side #(.ACK_ERR(ACK_ERR)) i_far
    (
        .clk, .go, .slow, .kind, .sa, .ad, .memAckValid,
        .controllerAcknowledgeCode, .systemBusAddress, .pciAddrData,
        .uncorrReadErr, .corrReadErr, .mapLookupInvalid, .noDeviceErr,
        .targetAbortErr, .ioParityErr, .dmaParityErr, .retryTimeoutErr
    );
    ////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        if (error_cnt == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish
    task automatic acc(input logic w, input logic [3:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk);
        address <= a;
        writedata <= d;
        write <= w;
        read <= !w;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (waitrequest !== 1'b0 && n < 20);
        if (n >= 20)
            error_cnt++;
        r = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask : acc
    task automatic fire(input logic [3:0] k, input logic [33:0] s,
                        input logic [31:0] a);
        @(posedge clk);
        kind <= k;
        sa <= s;
        ad <= a;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (4) @(posedge clk);
        @(negedge clk);
    endtask : fire
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial
    begin
        repeat (3000) @(posedge clk);
        error_cnt++;
        tally_and_finish();
    end
    initial
    begin
        {rst, read, write, go, slow} = 5'h10;
        {address, kind, writedata, sa, ad} = '0;
        byteenable = 4'hF;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        `RD(OFF_DIAG, 32'h0)
        `RD(OFF_IRQ_MASK, 32'h0)
        for (int i = 0; i < 10; i++)
        begin
            slow <= i[0];
            sv = 34'h2DEADBEE0 + 34'(i * 64);
            fire(rows[i].k, sv, 32'hC0DE0000 + 32'(i));
            `RD(OFF_DIAG, {16'h0, rows[i].f})
            e = (rows[i].o == OFF_PCI_ADDR) ? 32'hC0DE0000 + 32'(i) : 32'h0;
            if (rows[i].o == OFF_SYS_ADDR)
                e = {sv[33:6], 4'h0};
            `RD(rows[i].o, e)
            acc(1'b1, OFF_DIAG, {16'h0, rows[i].f}, q);
            `RD(OFF_DIAG, 32'h0)
        end
        sv = 34'h1ABCDEF40;
        fire(4'h2, sv, 32'h0);
        fire(4'h0, 34'h200000040, 32'h0);
        `RD(OFF_DIAG, 32'h00002040)
        `RD(OFF_SYS_ADDR, {sv[33:6], 4'h0})
        acc(1'b1, OFF_DIAG, 32'h0000FF60, q);
        sv2 = 34'h0F0F0F0C0;
        fire(4'h0, sv2, 32'h0);
        fire(4'h3, sv, 32'h0);
        acc(1'b1, OFF_DIAG, 32'h0, q);
        `RD(OFF_DIAG, 32'h00009040)
        acc(1'b1, OFF_DIAG, 32'h00008000, q);
        fire(4'h2, sv, 32'h0);
        `RD(OFF_DIAG, 32'h00003040)
        `RD(OFF_SYS_ADDR, {sv2[33:6], 4'h0})
        acc(1'b1, OFF_DIAG, 32'h0000FF60, q);
        fire(4'h4, sv, 32'h13572468);
        fire(4'h5, sv, 32'h9ABCDEF0);
        `RD(OFF_DIAG, 32'h00004840)
        `RD(OFF_PCI_ADDR, 32'h13572468)
        acc(1'b1, OFF_DIAG, 32'hFFFFFFFF, q);
        `RD(OFF_DIAG, 32'h00000008)
        fire(4'h3, sv, 32'h0);
        `RD(OFF_DIAG, 32'h00000008)
        `RD(OFF_SYS_ADDR, {sv2[33:6], 4'h0})
        acc(1'b1, OFF_DIAG, 32'h0, q);
        fire(4'h3, sv, 32'h0);
        `RD(OFF_DIAG, 32'h00001000)
        acc(1'b1, OFF_DIAG, 32'h0000FF60, q);
        acc(1'b1, OFF_IRQ_MASK, 32'hFFFFFFFF, q);
        `RD(OFF_IRQ_MASK, 32'h0000FF60)
        acc(1'b1, OFF_IRQ_MASK, 32'h00000800, q);
        fire(4'h6, sv, 32'h0);
        `CHK(irq, 1'b0)
        fire(4'h5, sv, 32'h0);
        `CHK(irq, 1'b1)
        acc(1'b1, 4'h1, 32'hFFFFFFFF, q);
        `RD(4'h1, 32'h0)
        `RD(OFF_DIAG, 32'h00000C40)
        acc(1'b1, OFF_DIAG, 32'h00000800, q);
        repeat (2) @(negedge clk);
        `CHK(irq, 1'b0)
        @(posedge clk);
        byteenable <= 4'h1;
        acc(1'b1, OFF_IRQ_MASK, 32'hFFFFFF60, q);
        byteenable <= 4'hF;
        `RD(OFF_IRQ_MASK, 32'h00000860)
        @(negedge clk);
        `CHK(irq, 1'b1)
        tally_and_finish();
    end
endmodule : bridge_error_status_logging_test
bind besl_error_log besl_error_log_props i_props
(
    .clk, .rst, .address, .read, .write, .readdata, .waitrequest, .irq
);
